// [sac_map.svh]
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
// Clock period and timing figures
`define SAC_CLK_NS          20
`define SAC_CONV_MIN_NS     25
`define SAC_CONV_MIN_CYC    ((`SAC_CONV_MIN_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_THRU_MAX_NS     8500
`define SAC_THRU_MAX_CYC    (`SAC_THRU_MAX_NS / `SAC_CLK_NS)
// Sequencing counts
`define SAC_RES_BITS        12
`define SAC_SHORT_BITS      8
`define SAC_ACQ_CYC         16
`define SAC_LATCH_CYC       2
`define SAC_SETTLE_CYC      2
// Result codes
`define SAC_CODE_ZERO       12'h000
`define SAC_CODE_MID        12'h800
`define SAC_CODE_FULL       12'hFFF
// Host command register offsets
`define SAC_REG_CTRL        12'h000
`define SAC_REG_STAT        12'h004
`define SAC_REG_DATA        12'h008
// Control register field positions
`define SAC_CTRL_START      0
`define SAC_CTRL_READ       1
`define SAC_CTRL_SHORT      2
`define SAC_CTRL_WIDE       3
`define SAC_CTRL_LOWBYTE    4
`endif

// [sac_pkg.sv]
package sac_pkg;
  // Converter sequencer states
  typedef enum logic [1:0] {
    SAC_TRACK,
    SAC_APPROX,
    SAC_LATCH
  } sac_conv_state_type;
  // Host sequencer states
  typedef enum logic [2:0] {
    SAC_H_IDLE,
    SAC_H_CONV,
    SAC_H_WAIT_BUSY,
    SAC_H_WAIT_DONE,
    SAC_H_READ_SET,
    SAC_H_READ_TAKE
  } sac_host_state_type;
  typedef logic [11:0] sac_word_type;
endpackage

// [sac_link_if.sv]
`timescale 1ns/10ps
// Control strobes, status and three-state data bus between host and converter
interface sac_link_if;
  logic        chip_en;          // Chip enable, active high
  logic        chip_sel_n;       // Chip select, active low
  logic        read_convert;     // 1 = read, 0 = convert
  logic        byte_addr_short;  // Byte select / short cycle
  logic        data_width_sel;   // 1 = all twelve bits
  logic        status;           // High while converting
  logic [11:0] data_out;         // Data bus value
  logic [11:0] data_oe;          // Per-bit output enable
  modport device (
    input  chip_en, chip_sel_n, read_convert, byte_addr_short, data_width_sel,
    output status, data_out, data_oe
  );
  modport host (
    output chip_en, chip_sel_n, read_convert, byte_addr_short, data_width_sel,
    input  status, data_out, data_oe
  );
endinterface

// [sac_device.sv]
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "sac_map.svh"
module sac_device
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic  i_core_clk,
  input  wire logic  i_reset,
  // Link to host
  sac_link_if.device link,
  // Analog comparator: 1 when input is above the trial code
  input  wire logic  i_comp_above,
  // Sampler and trial code to the analog array
  output logic       o_sample_hold,
  output logic [11:0] o_trial_code,
  output logic       o_tracking
);

  // ----------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------
  // Control pins come from another domain; two flops before use
  logic [4:0] sync_a;          // First stage, read only by sync_b
  logic [4:0] sync_b;          // Second stage
  logic [4:0] sync_prev;       // Delayed copy for edge detection
  logic       comp_a;          // Comparator first stage
  logic       comp_b;          // Comparator second stage

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      // Idle pin levels (read high, deselected) so no false edge follows reset
      sync_a    <= 5'h16;
      sync_b    <= 5'h16;
      sync_prev <= 5'h16;
      comp_a    <= 1'b0;
      comp_b    <= 1'b0;
    end else begin
      sync_a    <= {link.data_width_sel, link.byte_addr_short, link.read_convert,
                    link.chip_sel_n, link.chip_en};
      sync_b    <= sync_a;
      sync_prev <= sync_b;
      comp_a    <= i_comp_above;
      comp_b    <= comp_a;
    end
  end

  logic ce, cs_n, rc, short_in, wide_in;
  logic ce_p, cs_n_p, rc_p;
  assign ce       = sync_b[0];
  assign cs_n     = sync_b[1];
  assign rc       = sync_b[2];
  assign short_in = sync_b[3];
  assign wide_in  = sync_b[4];
  assign ce_p     = sync_prev[0];
  assign cs_n_p   = sync_prev[1];
  assign rc_p     = sync_prev[2];

  // ----------------------------------------------------------
  // Start detection
  // ----------------------------------------------------------
  // Start on the last of the three inputs to reach its state; the
  // level term with a change of any of them covers simultaneous moves
  logic start_ok;
  logic start_edge;
  assign start_ok   = ce && !cs_n && !rc;
  assign start_edge = start_ok && (!ce_p || cs_n_p || rc_p);

  // ----------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------
  sac_conv_state_type state;       // Sequencer state
  sac_conv_state_type next_state;
  logic [11:0] result;             // Output data register
  logic [11:0] next_result;
  logic [11:0] trial;              // Bits decided so far plus trial bit
  logic [11:0] next_trial;
  logic [3:0]  bit_idx;            // Bit under trial
  logic [3:0]  next_bit_idx;
  logic        short_cyc;          // Captured short-cycle select
  logic        next_short_cyc;
  logic [1:0]  latch_cnt;          // Settle before status falls
  logic [1:0]  next_latch_cnt;
  logic        busy;               // Status register
  logic        next_busy;
  logic        hold;               // Sampler in hold
  logic        next_hold;
  logic [1:0]  settle_cnt;         // Cycles left for the synced comparator
  logic [1:0]  next_settle_cnt;

  // Lowest bit index trialled for the chosen length
  function automatic logic [3:0] last_bit(input logic is_short);
    last_bit = is_short ? 4'(`SAC_RES_BITS - `SAC_SHORT_BITS) : 4'h0;
  endfunction

  always_comb begin
    next_state     = state;
    next_result    = result;
    next_trial     = trial;
    next_bit_idx   = bit_idx;
    next_short_cyc = short_cyc;
    next_latch_cnt = latch_cnt;
    next_busy      = busy;
    next_hold      = hold;
    next_settle_cnt = settle_cnt;
    case (state)
      SAC_TRACK: begin
        // The sequencer looks at the control pins only here, so pulses while busy are dropped
        if (start_edge) begin
          next_short_cyc = short_in;
          next_hold      = 1'b1;
          next_busy      = 1'b1;
          next_bit_idx   = 4'hB;
          next_trial     = `SAC_CODE_MID;
          next_settle_cnt = 2'(`SAC_SETTLE_CYC);
          next_state     = SAC_APPROX;
        end
      end
      SAC_APPROX: begin
        // The comparator reaches us through two flops, so a trial code must
        // stand that long before its decision; deciding earlier would judge
        // the code of an older step
        if (settle_cnt != 2'h0) begin
          next_settle_cnt = settle_cnt - 2'h1;
        end else begin
          next_settle_cnt = 2'(`SAC_SETTLE_CYC);
          // Keep the trial bit when the input is above it
          next_trial[bit_idx] = comp_b;
          if (bit_idx == last_bit(short_cyc)) begin
            next_result = next_trial;
            if (short_cyc)
              next_result[3:0] = 4'h0;
            next_hold      = 1'b0;
            next_latch_cnt = 2'(`SAC_LATCH_CYC);
            next_state     = SAC_LATCH;
          end else begin
            next_bit_idx = bit_idx - 4'h1;
            next_trial[bit_idx - 4'h1] = 1'b1;
          end
        end
      end
      SAC_LATCH: begin
        // Data settle on the output register before status drops
        if (latch_cnt == 2'h1) begin
          next_busy  = 1'b0;
          next_state = SAC_TRACK;
        end
        next_latch_cnt = latch_cnt - 2'h1;
      end
      default: next_state = SAC_TRACK;
    endcase
  end

  // Twelve steps plus sync and latch are far inside 8.5us at 50 MHz
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state     <= SAC_TRACK;
      result    <= `SAC_CODE_ZERO;
      trial     <= `SAC_CODE_ZERO;
      bit_idx   <= 4'h0;
      short_cyc <= 1'b0;
      latch_cnt <= 2'h0;
      busy      <= 1'b0;
      hold      <= 1'b0;
      settle_cnt <= 2'h0;
    end else begin
      state     <= next_state;
      result    <= next_result;
      trial     <= next_trial;
      bit_idx   <= next_bit_idx;
      short_cyc <= next_short_cyc;
      latch_cnt <= next_latch_cnt;
      busy      <= next_busy;
      hold      <= next_hold;
      settle_cnt <= next_settle_cnt;
    end
  end

  // ----------------------------------------------------------
  // Output bus
  // ----------------------------------------------------------
  logic [11:0] dout;
  logic [11:0] next_dout;
  logic [11:0] doe;
  logic [11:0] next_doe;

  // Byte mode is left-justified: the low byte rides on the lower eight lines
  always_comb begin
    next_dout = result;
    next_doe  = 12'h000;
    if (rc && !busy && ce && !cs_n) begin
      if (wide_in) begin
        next_doe = 12'hFFF;
      end else if (!short_in) begin
        next_doe = 12'hFF0;
      end else begin
        next_dout = {4'h0, result[3:0], 4'h0};
        next_doe  = 12'h0FF;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      dout <= 12'h000;
      doe  <= 12'h000;
    end else begin
      dout <= next_dout;
      doe  <= next_doe;
    end
  end

  assign link.status   = busy;
  assign link.data_out = dout;
  assign link.data_oe  = doe;
  assign o_sample_hold = hold;
  assign o_trial_code  = trial;
  assign o_tracking    = !hold;

endmodule

// [sac_host.sv]
`timescale 1ns/10ps
`include "sac_map.svh"
module sac_host
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Link to converter
  sac_link_if.host         link
);

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic        st_a, st_b;        // Status, two stages
  logic [11:0] d_a, d_b;          // Data bus, two stages
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_a <= 1'b0;
      st_b <= 1'b0;
      d_a  <= 12'h000;
      d_b  <= 12'h000;
    end else begin
      st_a <= link.status;
      st_b <= st_a;
      d_a  <= link.data_out & link.data_oe;
      d_b  <= d_a;
    end
  end

  // ----------------------------------------------------------
  // Sequencer and registers
  // ----------------------------------------------------------
  sac_host_state_type state, next_state;
  logic        ce, next_ce;          // Chip enable drive
  logic        rc, next_rc;          // Read/convert drive
  logic        shrt, next_shrt;      // Byte/short drive
  logic        wide, next_wide;      // Width select drive
  logic [3:0]  cnt, next_cnt;        // Pulse and settle counter
  logic [11:0] rdata, next_rdata;    // Last word read
  logic        done, next_done;      // Sticky done, set at the end of a conversion or a read
  logic [31:0] prdata, next_prdata;
  logic        pready, next_pready;

  logic wr_ctrl;    // Write lands at the edge where pready is seen high
  logic rd_load;    // Read word loaded one edge early so it stands with pready
  assign wr_ctrl = i_psel && i_penable && pready && i_pwrite && i_paddr == `SAC_REG_CTRL;
  assign rd_load = i_psel && i_penable && !pready;

  always_comb begin
    next_state  = state;
    next_ce     = ce;
    next_rc     = rc;
    next_shrt   = shrt;
    next_wide   = wide;
    next_cnt    = cnt;
    next_rdata  = rdata;
    next_done   = done;
    next_pready = rd_load;
    next_prdata = 32'h0000_0000;
    // Register reads: word held through the cycle in which pready is high
    if (rd_load) begin
      case (i_paddr)
        `SAC_REG_STAT: next_prdata = {29'h0, done, st_b, state != SAC_H_IDLE};
        `SAC_REG_DATA: next_prdata = {20'h0, rdata};
        default:       next_prdata = 32'h0000_0000;
      endcase
    end
    case (state)
      SAC_H_IDLE: begin
        if (wr_ctrl && i_pwdata[`SAC_CTRL_START]) begin
          next_shrt  = i_pwdata[`SAC_CTRL_SHORT];
          next_wide  = i_pwdata[`SAC_CTRL_WIDE];
          next_ce    = 1'b1;
          next_rc    = 1'b0;            // Falling read_convert starts
          next_cnt   = 4'(`SAC_CONV_MIN_CYC + 1);
          next_done  = 1'b0;
          next_state = SAC_H_CONV;
        end else if (wr_ctrl && i_pwdata[`SAC_CTRL_READ]) begin
          next_shrt  = i_pwdata[`SAC_CTRL_LOWBYTE];
          next_wide  = i_pwdata[`SAC_CTRL_WIDE];
          next_ce    = 1'b1;
          next_rc    = 1'b1;
          next_cnt   = 4'h6;
          next_done  = 1'b0;
          next_state = SAC_H_READ_SET;
        end
      end
      SAC_H_CONV: begin
        // Keep convert low at least 25ns
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_rc    = 1'b1;
          next_state = SAC_H_WAIT_BUSY;
        end
      end
      SAC_H_WAIT_BUSY: if (st_b) next_state = SAC_H_WAIT_DONE;
      SAC_H_WAIT_DONE: begin
        if (!st_b) begin
          next_ce    = 1'b0;
          next_done  = 1'b1;
          next_state = SAC_H_IDLE;
        end
      end
      SAC_H_READ_SET: begin
        // Wait for enables to reach the bus and pass the synchroniser
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) next_state = SAC_H_READ_TAKE;
      end
      SAC_H_READ_TAKE: begin
        next_rdata = d_b;
        next_ce    = 1'b0;
        next_done  = 1'b1;
        next_state = SAC_H_IDLE;
      end
      default: next_state = SAC_H_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state  <= SAC_H_IDLE;
      ce     <= 1'b0;
      rc     <= 1'b1;
      shrt   <= 1'b0;
      wide   <= 1'b1;
      cnt    <= 4'h0;
      rdata  <= 12'h000;
      done   <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
    end else begin
      state  <= next_state;
      ce     <= next_ce;
      rc     <= next_rc;
      shrt   <= next_shrt;
      wide   <= next_wide;
      cnt    <= next_cnt;
      rdata  <= next_rdata;
      done   <= next_done;
      prdata <= next_prdata;
      pready <= next_pready;
    end
  end

  assign o_prdata             = prdata;
  assign o_pready             = pready;
  assign o_pslverr            = 1'b0;
  assign link.chip_en         = ce;
  assign link.chip_sel_n      = 1'b0;
  assign link.read_convert    = rc;
  assign link.byte_addr_short = shrt;
  assign link.data_width_sel  = wide;

endmodule

// [sac_link_asserts.sv]
`timescale 1ns/10ps
module sac_link_asserts (
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_reset,
  // Host strobes
  input wire logic        chip_en,
  input wire logic        chip_sel_n,
  input wire logic        read_convert,
  input wire logic        byte_addr_short,
  input wire logic        data_width_sel,
  // Converter answers
  input wire logic        status,
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  // Width select steady long enough for its synced copy to agree
  sequence wide_hi;
    data_width_sel && $past(data_width_sel, 3) && $past(data_width_sel, 4);
  endsequence
  sequence wide_lo;
    !data_width_sel && !$past(data_width_sel, 3) && !$past(data_width_sel, 4);
  endsequence
  sequence read_on;
    data_oe != 12'h000;
  endsequence
  // Falling convert edge while selected and idle
  sequence sa_start;
    chip_en && !chip_sel_n && $fell(read_convert) && !status;
  endsequence
  sequence conv_run;
    status [*8];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  oe_idle_a: assert property (status |-> data_oe == 12'h000)
    else $error("outputs driven while converting");
  oe_cond_a: assert property (read_on |->
    $past(read_convert, 3) && $past(chip_en, 3) && !$past(chip_sel_n, 3))
    else $error("outputs driven without read conditions");
  oe_float_a: assert property ($fell(chip_en) |-> ##3 data_oe == 12'h000)
    else $error("outputs not floated after enable drop");
  wide_all_a: assert property (read_on ##0 wide_hi |-> data_oe == 12'hFFF)
    else $error("wide read not on all lines");
  byte_grp_a: assert property (read_on ##0 wide_lo |->
    data_oe inside {12'hFF0, 12'h0FF})
    else $error("byte read enabled wrong group");
  low_zero_a: assert property (data_oe == 12'h0FF |-> data_out[3:0] == 4'h0)
    else $error("low byte trailing bits not zero");
  start_rise_a: assert property (sa_start |-> ##[2:3] status)
    else $error("convert edge did not start");
  status_hold_a: assert property ($rose(status) |-> conv_run)
    else $error("status dropped early");
  conv_time_a: assert property ($rose(status) |-> ##[26:38] !status)
    else $error("conversion too long");
endmodule

// [sar_adc_host_control_test.sv]
`timescale 1ns/10ps
`include "sac_map.svh"
module sar_adc_host_control_test;
  // APB side and comparator inputs
  logic        i_core_clk = 1'b0;
  logic        i_reset    = 1'b1;
  logic        i_psel     = 1'b0;
  logic        i_penable  = 1'b0;
  logic        i_pwrite   = 1'b0;
  logic [11:0] i_paddr    = 12'h000;
  logic [31:0] i_pwdata   = 32'h0;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic [11:0] vin_a      = 12'h000;
  logic [11:0] vin_b      = 12'h000;
  logic [11:0] trial_a;
  logic [11:0] trial_b;
  logic        hold_b;
  logic        track_b;
  int          err_count  = 0;
  int          num_checks = 0;
  sac_link_if link_a();
  sac_link_if link_b();
  always #10 i_core_clk = ~i_core_clk;
  // Host and converter face each other on link_a
  sac_host i_sac_host (.i_core_clk, .i_reset, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr(), .link(link_a));
  // Comparator model: ideal, fed by the trial code
  sac_device i_sac_device (.i_core_clk, .i_reset, .link(link_a),
    .i_comp_above(vin_a >= trial_a), .o_sample_hold(), .o_trial_code(trial_a),
    .o_tracking());
  // Second converter driven pin by pin, since the host ties select low
  sac_device i_sac_device_b (.i_core_clk, .i_reset, .link(link_b),
    .i_comp_above(vin_b >= trial_b), .o_sample_hold(hold_b),
    .o_trial_code(trial_b), .o_tracking(track_b));
  sac_link_asserts i_sac_link_asserts (.i_core_clk, .i_reset,
    .chip_en(link_a.chip_en), .chip_sel_n(link_a.chip_sel_n),
    .read_convert(link_a.read_convert), .byte_addr_short(link_a.byte_addr_short),
    .data_width_sel(link_a.data_width_sel), .status(link_a.status),
    .data_out(link_a.data_out), .data_oe(link_a.data_oe));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [11:0] g, input logic [11:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_of_test;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] q);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    // Access phase lasts until pready is seen high; only the watchdog ends it
    do begin
      @(posedge i_core_clk);
    end while (o_pready !== 1'b1);
    q = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_core_clk);
  endtask
  // Poll status until idle with done set; commands only go out when idle
  task poll;
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      apb(1'b0, `SAC_REG_STAT, 32'h0, q);
      n++;
    end while ((q[0] !== 1'b0 || q[2] !== 1'b1) && n < 40);
    chk({9'h0, q[2:0]} & 12'h005, 12'h004);
  endtask
  task host_run(input logic [11:0] v, input logic [31:0] cv, input logic [31:0] rd,
                input logic [11:0] m, input logic [11:0] e);
    logic [31:0] q;
    vin_a <= v;
    apb(1'b1, `SAC_REG_CTRL, cv, q);
    poll;
    apb(1'b1, `SAC_REG_CTRL, rd, q);
    poll;
    apb(1'b0, `SAC_REG_DATA, 32'h0, q);
    chk(q[11:0] & m, e);
  endtask
  // Wait a bounded time for device b status to reach v
  task wst(input logic v);
    int n;
    n = 0;
    while (link_b.status !== v && n < 40) begin
      @(posedge i_core_clk);
      n++;
    end
    chk({11'h0, link_b.status}, {11'h0, v});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_codes;
    logic [11:0] lv [4];
    lv = '{12'h000, 12'h800, 12'hFFF, 12'h5A3};
    foreach (lv[i]) begin
      host_run(lv[i], 32'h1, 32'hA, 12'hFFF, lv[i]);
    end
  endtask
  task t_bytes;
    logic [31:0] q;
    host_run(12'h5A7, 32'h1, 32'h12, 12'h0FF, 12'h070);
    host_run(12'h5A7, 32'h5, 32'h2, 12'hFF0, 12'h5A0);
    host_run(12'h5A7, 32'h5, 32'hA, 12'hFFF, 12'h5A0);
    // Unmapped offset reads back zero
    apb(1'b0, 12'h010, 32'h0, q);
    chk(q[11:0], 12'h000);
  endtask
  // Select-edge start, pulses during conversion, then every read format
  task t_pins;
    vin_b <= 12'hC3D;
    link_b.chip_sel_n <= 1'b0;
    link_b.read_convert <= 1'b0;
    step(6);
    chk({11'h0, link_b.status}, 12'h000);
    link_b.chip_sel_n <= 1'b1;
    link_b.chip_en <= 1'b1;
    step(6);
    chk({11'h0, link_b.status}, 12'h000);
    link_b.chip_sel_n <= 1'b0;
    wst(1'b1);
    chk({11'h0, hold_b}, 12'h001);
    link_b.read_convert <= 1'b1;
    step(2);
    link_b.read_convert <= 1'b0;
    step(2);
    wst(1'b0);
    chk({11'h0, track_b}, 12'h001);
    step(6);
    chk({11'h0, link_b.status}, 12'h000);
    link_b.data_width_sel <= 1'b0;
    link_b.read_convert <= 1'b1;
    step(5);
    chk(link_b.data_oe, 12'hFF0);
    chk(link_b.data_out & 12'hFF0, 12'hC30);
    link_b.byte_addr_short <= 1'b1;
    step(5);
    chk(link_b.data_oe, 12'h0FF);
    chk(link_b.data_out & 12'h0FF, 12'h0D0);
    link_b.data_width_sel <= 1'b1;
    step(5);
    chk(link_b.data_oe, 12'hFFF);
    chk(link_b.data_out, 12'hC3D);
    link_b.chip_en <= 1'b0;
    step(4);
    chk(link_b.data_oe, 12'h000);
  endtask
  // Enable-edge start of a short cycle; short input moved after start
  task t_ce_start;
    vin_b <= 12'h9E7;
    link_b.read_convert <= 1'b0;
    step(4);
    chk({11'h0, link_b.status}, 12'h000);
    link_b.chip_en <= 1'b1;
    wst(1'b1);
    link_b.byte_addr_short <= 1'b0;
    wst(1'b0);
    link_b.read_convert <= 1'b1;
    step(5);
    chk(link_b.data_out, 12'h9E0);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    link_b.chip_en = 1'b0;
    link_b.chip_sel_n = 1'b1;
    link_b.read_convert = 1'b1;
    link_b.byte_addr_short = 1'b0;
    link_b.data_width_sel = 1'b1;
    step(2);
    i_reset <= 1'b0;
    step(3);
    t_codes;
    t_bytes;
    t_pins;
    t_ce_start;
    end_of_test;
  end
  // Whole run needs under a thousand cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge i_core_clk);
    err_count++;
    end_of_test;
  end
endmodule
